// ---- core/pvc_regs.sv ----
// Power-control and eye-tuning registers with set and clear aliases
//
// Notes on behaviour
// - Offset 0x3E sets power-control bits written as 1; reads return power-control.
// - Offsets 0x3F and 0x82 clear bits written as 1; reads return base register.
// - Offset 0x81 sets eye-tuning bits written as 1; reads return eye-tuning value.
// - Eye bit 6 is line polarity, reset 1; bit 7 spare, reset 0.
// - Eye bits 5:4 select high-speed output impedance, reset 0.
// - Eye bits 3:0 select high-speed drive strength, reset 1.
// - Drive strength bit 0 also enables the transmit boost.
// - Enabled session-valid edges send a receive command with alternate interrupt set.
// - Enabled supply, ID-float, ID-resistor, stress edges each send a receive command.
`timescale 1ns/10ps
module pvc_regs
  import pvc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register access from the link
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // Internal event sources, unsynchronised
  input wire logic session_valid,
  input wire logic supply_ok,
  input wire logic id_floating,
  input wire logic [EV_RES_W-1:0] id_resistor,
  input wire logic line_stress,
  // Receive command request
  output logic rx_cmd_req,
  output logic rx_cmd_alt_int,
  // Analog controls
  output logic line_polarity_ctrl,
  output logic [EYE_ZHS_W-1:0] hs_output_impedance_sel,
  output logic [EYE_IHS_W-1:0] hs_drive_strength_sel,
  output logic transmit_boost_enable,
  output logic supply_monitor_event_enable,
  output logic id_floating_event_enable,
  output logic id_resistor_event_enable,
  output logic line_stress_event_enable
);
  logic [DATA_W-1:0] pwr_ff;
  logic [DATA_W-1:0] nxt_pwr;
  logic [DATA_W-1:0] eye_ff;
  logic [DATA_W-1:0] nxt_eye;
  logic [DATA_W-1:0] rdata_ff;
  logic rd_valid_ff;
  logic rx_req_ff;
  logic rx_alt_ff;
  logic [NUM_EV-1:0] raw_ev;
  logic [NUM_EV-1:0] any_edge;
  logic sv_hit;
  logic dbg_hit;

  pvc_evt_if #(.W(NUM_EV)) evt ();

  assign raw_ev = {line_stress, id_resistor, id_floating, supply_ok, session_valid};

  pvc_edge_det #(.W(NUM_EV)) u_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .raw(raw_ev),
    .evt(evt.src)
  );

  // Aliases have no storage; they only shape the next value
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_eye = eye_ff;
    if (reg_wr_en) begin
      case (reg_addr)
        OFS_PWR: nxt_pwr = reg_wdata;
        OFS_PWR_SET: nxt_pwr = pwr_ff | reg_wdata;
        OFS_PWR_CLR: nxt_pwr = pwr_ff & ~reg_wdata;
        OFS_EYE: nxt_eye = reg_wdata;
        OFS_EYE_SET: nxt_eye = eye_ff | reg_wdata;
        OFS_EYE_CLR: nxt_eye = eye_ff & ~reg_wdata;
        default: begin
          nxt_pwr = pwr_ff;
          nxt_eye = eye_ff;
        end
      endcase
    end
  end

  // Spare bits are stored as written; the link keeps power bits 7 and 1 at 0 but sets eye bit 7
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_ff <= PWR_RST;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eye_ff <= EYE_RST;
    end else begin
      eye_ff <= nxt_eye;
    end
  end

  // Read of the next value so a same-cycle write is already visible
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_ff <= RD_UNMAPPED;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          OFS_PWR, OFS_PWR_SET, OFS_PWR_CLR: rdata_ff <= nxt_pwr;
          OFS_EYE, OFS_EYE_SET, OFS_EYE_CLR: rdata_ff <= nxt_eye;
          default: rdata_ff <= RD_UNMAPPED;
        endcase
      end
    end
  end

  assign any_edge = evt.rise | evt.fall;
  assign sv_hit = (evt.rise[EV_SV] & pwr_ff[PWR_SV_RISE_BIT])
                | (evt.fall[EV_SV] & pwr_ff[PWR_SV_FALL_BIT]);
  assign dbg_hit = (any_edge[EV_SUP] & pwr_ff[PWR_SUPPLY_BIT])
                 | (any_edge[EV_FLT] & pwr_ff[PWR_FLOAT_BIT])
                 | ((|any_edge[EV_RES_LSB +: EV_RES_W]) & pwr_ff[PWR_IDRES_BIT])
                 | (any_edge[EV_STR] & pwr_ff[PWR_STRESS_BIT]);

  // Edges in one cycle merge into a single request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_req_ff <= 1'b0;
      rx_alt_ff <= 1'b0;
    end else begin
      rx_req_ff <= sv_hit | dbg_hit;
      rx_alt_ff <= sv_hit;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rd_valid = rd_valid_ff;
  assign rx_cmd_req = rx_req_ff;
  assign rx_cmd_alt_int = rx_alt_ff;
  assign line_polarity_ctrl = eye_ff[EYE_POL_BIT];
  assign hs_output_impedance_sel = eye_ff[EYE_ZHS_LSB +: EYE_ZHS_W];
  assign hs_drive_strength_sel = eye_ff[EYE_IHS_LSB +: EYE_IHS_W];
  assign transmit_boost_enable = eye_ff[EYE_BOOST_BIT];
  assign supply_monitor_event_enable = pwr_ff[PWR_SUPPLY_BIT];
  assign id_floating_event_enable = pwr_ff[PWR_FLOAT_BIT];
  assign id_resistor_event_enable = pwr_ff[PWR_IDRES_BIT];
  assign line_stress_event_enable = pwr_ff[PWR_STRESS_BIT];

  property p_pwr_set;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_PWR_SET |=> pwr_ff == ($past(pwr_ff) | $past(reg_wdata));
  endproperty
  a_pwr_set: assert property (p_pwr_set) else $error("power set alias wrong");

  property p_pwr_clr;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_PWR_CLR |=> pwr_ff == ($past(pwr_ff) & ~$past(reg_wdata));
  endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power clear alias wrong");

  property p_eye_clr;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_EYE_CLR |=> eye_ff == ($past(eye_ff) & ~$past(reg_wdata));
  endproperty
  a_eye_clr: assert property (p_eye_clr) else $error("eye clear alias wrong");

  property p_eye_set;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_EYE_SET |=> eye_ff == ($past(eye_ff) | $past(reg_wdata));
  endproperty
  a_eye_set: assert property (p_eye_set) else $error("eye set alias wrong");

  property p_eye_reset;
    @(posedge core_clk) $fell(sys_rst) |-> line_polarity_ctrl && eye_ff[DATA_W-1] == 1'b0;
  endproperty
  a_eye_reset: assert property (p_eye_reset) else $error("polarity reset wrong");

  property p_fields_reset;
    @(posedge core_clk) $fell(sys_rst) |-> hs_output_impedance_sel == '0 && hs_drive_strength_sel == 4'h1;
  endproperty
  a_fields_reset: assert property (p_fields_reset) else $error("eye field reset wrong");

  property p_boost;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_EYE |=> transmit_boost_enable == $past(reg_wdata[EYE_BOOST_BIT]);
  endproperty
  a_boost: assert property (p_boost) else $error("boost not tied to drive bit");

  property p_sv_cmd;
    @(posedge core_clk) disable iff (sys_rst)
    sv_hit |=> rx_cmd_req && rx_cmd_alt_int;
  endproperty
  a_sv_cmd: assert property (p_sv_cmd) else $error("session edge gave no alt command");

  property p_dbg_cmd;
    @(posedge core_clk) disable iff (sys_rst)
    dbg_hit && !sv_hit |=> rx_cmd_req && !rx_cmd_alt_int;
  endproperty
  a_dbg_cmd: assert property (p_dbg_cmd) else $error("debug edge gave wrong command");

  property p_rd_cons;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && (reg_addr == OFS_PWR_SET || reg_addr == OFS_PWR_CLR) |=> reg_rd_valid && reg_rdata == pwr_ff;
  endproperty
  a_rd_cons: assert property (p_rd_cons) else $error("alias read not updated value");

  property p_eye_rd_cons;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && (reg_addr == OFS_EYE_SET || reg_addr == OFS_EYE_CLR) |=> reg_rd_valid && reg_rdata == eye_ff;
  endproperty
  a_eye_rd_cons: assert property (p_eye_rd_cons) else $error("eye alias read not updated value");

  property p_eye_rd;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd_en && reg_addr == OFS_EYE |=> reg_rd_valid && reg_rdata == eye_ff;
  endproperty
  a_eye_rd: assert property (p_eye_rd) else $error("eye read wrong");

  property p_no_cmd;
    @(posedge core_clk) disable iff (sys_rst)
    !(sv_hit || dbg_hit) |=> !rx_cmd_req;
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("command without enabled edge");
endmodule

// ---- core/pvc_pkg.sv ----
// Offsets, field positions and reset values of the vendor control registers
package pvc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_PWR = 8'h3d;
  localparam logic [7:0] OFS_PWR_SET = 8'h3e;
  localparam logic [7:0] OFS_PWR_CLR = 8'h3f;
  localparam logic [7:0] OFS_EYE = 8'h80;
  localparam logic [7:0] OFS_EYE_SET = 8'h81;
  localparam logic [7:0] OFS_EYE_CLR = 8'h82;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] EYE_RST = 8'h41;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Power-control field positions
  localparam int PWR_SUPPLY_BIT = 6;
  localparam int PWR_FLOAT_BIT = 5;
  localparam int PWR_IDRES_BIT = 4;
  localparam int PWR_SV_FALL_BIT = 3;
  localparam int PWR_SV_RISE_BIT = 2;
  localparam int PWR_STRESS_BIT = 0;
  // Eye-tuning field positions
  localparam int EYE_POL_BIT = 6;
  localparam int EYE_ZHS_LSB = 4;
  localparam int EYE_ZHS_W = 2;
  localparam int EYE_IHS_LSB = 0;
  localparam int EYE_IHS_W = 4;
  localparam int EYE_BOOST_BIT = 0;
  // Event vector layout
  localparam int EV_SV = 0;
  localparam int EV_SUP = 1;
  localparam int EV_FLT = 2;
  localparam int EV_RES_LSB = 3;
  localparam int EV_RES_W = 3;
  localparam int EV_STR = 6;
  localparam int NUM_EV = 7;
endpackage

// ---- core/pvc_evt_if.sv ----
// Edge events passed from the synchroniser to the register bank
`timescale 1ns/10ps
interface pvc_evt_if #(parameter int W = 7);
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// ---- core/pvc_edge_det.sv ----
// Two-stage synchroniser and edge detector for analog event sources
`timescale 1ns/10ps
module pvc_edge_det #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Asynchronous sources
  input wire logic [W-1:0] raw,
  // Edge events
  pvc_evt_if.src evt
);
  logic [W-1:0] sync1_ff;
  logic [W-1:0] sync2_ff;
  logic [W-1:0] prev_ff;
  logic [2:0] primed_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  // No edges until the history holds a real sample
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_ff <= '0;
      primed_ff <= '0;
    end else begin
      prev_ff <= sync2_ff;
      // One stage per flop a sample crosses; a high pin at reset gives no false edge
      primed_ff <= {primed_ff[1:0], 1'b1};
    end
  end

  assign evt.rise = primed_ff[2] ? (sync2_ff & ~prev_ff) : '0;
  assign evt.fall = primed_ff[2] ? (~sync2_ff & prev_ff) : '0;
endmodule

// ---- tb/pvc_link_model.sv ----
// Link-side model issuing register reads and writes
`timescale 1ns/10ps
module pvc_link_model
  import pvc_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Register access
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(posedge core_clk);
    reg_wr_en <= wr;
    reg_rd_en <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the vendor control registers
`timescale 1ns/10ps
module tb
  import pvc_pkg::*;
;
  logic core_clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, rx_cmd_req, rx_cmd_alt_int;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic session_valid, supply_ok, id_floating, line_stress, v, pol, boost;
  logic [2:0] id_resistor;
  logic [1:0] imp;
  logic [3:0] drv;
  logic sup_en, flt_en, res_en, str_en;
  int n_fail, checks, cyc;
  pvc_regs pvc_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .session_valid(session_valid), .supply_ok(supply_ok),
    .id_floating(id_floating), .id_resistor(id_resistor), .line_stress(line_stress),
    .rx_cmd_req(rx_cmd_req), .rx_cmd_alt_int(rx_cmd_alt_int), .line_polarity_ctrl(pol),
    .hs_output_impedance_sel(imp), .hs_drive_strength_sel(drv), .transmit_boost_enable(boost),
    .supply_monitor_event_enable(sup_en), .id_floating_event_enable(flt_en),
    .id_resistor_event_enable(res_en), .line_stress_event_enable(str_en));
  pvc_link_model pvc_link_model_inst (.core_clk(core_clk), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pvc_link_model_inst.xfer(1'b1, 1'b0, a, d, q, v);
  endtask
  // Read with its valid flag checked too
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    pvc_link_model_inst.xfer(1'b0, 1'b1, a, 8'h00, q, v);
    chk({7'h0, v}, 8'h01);
    chk(q, e);
  endtask
  task automatic chk_eye(input logic [7:0] e);
    chk({1'b0, pol, imp, drv}, e & 8'h7f);
    chk({7'h0, boost}, {7'h0, e[0]});
  endtask
  task automatic chk_pwr(input logic [7:0] p);
    chk({4'h0, sup_en, flt_en, res_en, str_en}, {4'h0, p[6], p[5], p[4], p[0]});
  endtask
  // Bounded wait; result packs {cycles with a request, alternate interrupt}
  task automatic ev(input logic [7:0] e);
    logic [7:0] got;
    got = 8'h00;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      if (rx_cmd_req === 1'b1) got = {got[7:1] + 7'h01, rx_cmd_alt_int};
    end
    chk(got, e);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {sys_rst, session_valid, supply_ok, id_floating, line_stress} = 5'b10000;
    id_resistor = 3'h0;
    {n_fail, checks, cyc} = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_PWR, 8'h00);
    rd(OFS_EYE, 8'h41);
    chk_eye(8'h41);
    // Link keeps spare power bits 7 and 1 at zero
    wr(OFS_PWR_SET, 8'h04);
    @(posedge core_clk) session_valid <= 1'b1;
    ev(8'h03);
    @(posedge core_clk) line_stress <= 1'b1;
    ev(8'h00);
    wr(OFS_PWR_SET, 8'h01);
    @(posedge core_clk) line_stress <= 1'b0;
    ev(8'h02);
    @(posedge core_clk) session_valid <= 1'b0;
    ev(8'h00);
    wr(OFS_PWR_SET, 8'h40);
    @(posedge core_clk) supply_ok <= 1'b1;
    ev(8'h02);
    wr(OFS_PWR_SET, 8'h20);
    @(posedge core_clk) id_floating <= 1'b1;
    ev(8'h02);
    wr(OFS_PWR_CLR, 8'hff);
    rd(OFS_PWR_CLR, 8'h00);
    wr(OFS_PWR_SET, 8'h75);
    rd(OFS_PWR_SET, 8'h75);
    chk_pwr(8'h75);
    wr(OFS_PWR_CLR, 8'h14);
    rd(OFS_PWR, 8'h61);
    chk_pwr(8'h61);
    wr(OFS_EYE, 8'h00);
    wr(OFS_EYE_SET, 8'h3e);
    rd(OFS_EYE_SET, 8'h3e);
    chk_eye(8'h3e);
    wr(OFS_EYE_CLR, 8'h31);
    rd(OFS_EYE_CLR, 8'h0e);
    wr(OFS_EYE_SET, 8'hc1);
    rd(OFS_EYE, 8'hcf);
    chk_eye(8'hcf);
    pvc_link_model_inst.xfer(1'b1, 1'b1, OFS_EYE_CLR, 8'h0f, q, v);
    chk(q, 8'hc0);
    chk({7'h0, v}, 8'h01);
    rd(OFS_EYE, 8'hc0);
    wr(8'h40, 8'hff);
    rd(8'h40, RD_UNMAPPED);
    rd(OFS_PWR, 8'h61);
    // Resistor lines and the falling session-valid enable
    wr(OFS_PWR_SET, 8'h18);
    @(posedge core_clk) id_resistor <= 3'h2;
    ev(8'h02);
    @(posedge core_clk) session_valid <= 1'b1;
    ev(8'h00);
    @(posedge core_clk) session_valid <= 1'b0;
    ev(8'h03);
    // Reset in mid-run with pins high; no false edge may follow release
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(OFS_PWR_SET, 8'h40);
    ev(8'h00);
    rd(OFS_EYE, 8'h41);
    rd(OFS_PWR_CLR, 8'h40);
    conclude();
  end
endmodule
